// ---- common/vhi_pkg.sv ----
// vhi_pkg: constants, enumerations and carriers of the display host interface.
// assumes a single 200 MHz clock (pclk) shared by every design file.
package vhi_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS = 5;                 // pclk period in ns
	localparam int T_RSTD_MS = 100;            // power-up internal reset delay, ms
	localparam int RSTD_CYC = T_RSTD_MS * 1000000 / CLK_NS;
	localparam int T_WAIT_NS = 1000;           // serial read wait, least, ns
	localparam int WAIT_CYC = (T_WAIT_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// apb register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;   // ro + w1c status
	localparam logic [7:0] REG_RX = 8'h04;       // last received word, read clears valid
	localparam logic [7:0] REG_TX_INSTR = 8'h08; // value returned on instruction reads
	localparam logic [7:0] REG_TX_DATA = 8'h0C;  // value returned on data reads

	// status fields
	localparam int ST_RX_VALID = 0;
	localparam int ST_READY = 1;
	localparam int ST_OVERRUN = 2;
	localparam int ST_FRAME_ERR = 3;
	localparam int ST_MODE_LSB = 4;
	localparam int ST_WIDTH = 6;
	// rx field
	localparam int RX_RS_BIT = 8;
	// reset values
	localparam logic [7:0] TX_RST = 8'h00;

	// serial start byte: five ones lead it
	localparam logic [4:0] HDR_SYNC = 5'h1F;

	// ----------------------------------------------------------------
	// enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ENABLE = 2'b00,  // enable_strobe_mode
		MODE_SPLIT = 2'b01,   // split_strobe_mode
		MODE_SERIAL = 2'b11,  // synchronous serial
		MODE_NONE = 2'b10     // illegal jumper code, interface dead
	} vhi_mode_t;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_HEAD = 2'b01,
		SER_BODY = 2'b11,
		SER_SKIP = 2'b10
	} vhi_ser_t;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic e;
		logic rw;
		logic rs;
		logic wr_n;
		logic rd_n;
		logic strobe_n;
		logic sck;
		logic sio;
		logic [7:0] db;
		logic [1:0] jmp_mode;
		logic jmp_width;
	} vhi_pins_t;

	typedef struct packed {
		logic rs;
		logic [7:0] val;
	} vhi_word_t;

endpackage

// ---- core/vhi_sync.sv ----
// vhi_sync: two-flop synchroniser for a bundle of asynchronous pins.
// assumes each bit is an independent level; multi-bit words must be stable
// around the moment a strobe edge that qualifies them is seen.
`timescale 1ns/1ps
module vhi_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r; // first stage, read by the second stage only

	// ----------------------------------------------------------------
	// two stages
	// ----------------------------------------------------------------
	// reset to zero; spurious edges at release are masked by the power-up wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // vhi_sync

// ---- core/vhi_por.sv ----
// vhi_por: internal power-up reset timer.
// assumes presetn models power arriving; done rises once the delay has run.
`timescale 1ns/1ps
module vhi_por #(
	parameter int CYC = 20000000,
	parameter int CW = 25
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// status
	output logic done
);
	localparam logic [CW-1:0] LAST = CW'(CYC - 1);
	logic [CW-1:0] cnt_r; // cycles since release

	// ----------------------------------------------------------------
	// delay counter
	// ----------------------------------------------------------------
	// counts up once and then parks with done high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			done <= 1'b0;
		end else if (!done) begin
			cnt_r <= cnt_r + 1'b1;
			done <= (cnt_r == LAST);
		end
	end
endmodule // vhi_por

// ---- core/vhi_host_if.sv ----
// vhi_host_if: host command/data port of the display controller, with apb registers.
// assumes all host pins are asynchronous to pclk, the host strobes slower than ~4 pclk,
// and software drains received words through the rx register.
//
// Contract
// - jumpers pick enable, split or serial mode
// - parallel words move as two nibbles or one byte
// - nibble mode: high nibble first, upper lines only
// - byte mode: whole byte on all eight lines
// - reg_select low instruction, high display data
// - enable mode: capture on strobe fall, rw low
// - enable mode: drive read data after strobe rise
// - split mode: capture on write strobe rise
// - split mode: drive read data after read fall
// - serial cycle is two bytes, msb first
// - start byte: five ones, rw, rs, zero
// - start rw bit set means read
// - start rs bit set means display data
// - serial write bits sampled on clock rise
// - serial read bits out after clock falls, post-wait
// - frame strobe bounds cycle; valid only on rise
// - device resets itself at power-up
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module vhi_host_if
	import vhi_pkg::*;
#(
	parameter int POR_CYC = RSTD_CYC,
	parameter int WAIT_CYCLES = WAIT_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// jumpers
	input wire logic [1:0] jmp_mode,
	input wire logic jmp_byte_wide,
	// parallel control pins
	input wire logic xfer_strobe,
	input wire logic read_write,
	input wire logic reg_select,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	// parallel data bus, three signals
	input wire logic [7:0] data_bus_in,
	output logic [7:0] data_bus_out,
	output logic data_bus_oe_n,
	// serial pins
	input wire logic frame_strobe_n,
	input wire logic shift_clk,
	input wire logic sio_in,
	output logic sio_out,
	output logic sio_oe_n
);
	localparam logic [7:0] WAIT_LD = 8'(WAIT_CYCLES);

	// ----------------------------------------------------------------
	// pin synchronisation and edges
	// ----------------------------------------------------------------
	vhi_pins_t pins_raw; // raw pin bundle
	vhi_pins_t pins_s;   // after two flops
	vhi_pins_t pins_q;   // one cycle older, for edge finding
	assign pins_raw = '{e: xfer_strobe, rw: read_write, rs: reg_select,
		wr_n: write_strobe_n, rd_n: read_strobe_n, strobe_n: frame_strobe_n,
		sck: shift_clk, sio: sio_in, db: data_bus_in, jmp_mode: jmp_mode,
		jmp_width: jmp_byte_wide};

	vhi_sync #(.W($bits(vhi_pins_t))) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pins_raw),
		.q(pins_s)
	);

	// edge reference stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pins_q <= '0;
		else pins_q <= pins_s;
	end

	wire e_fall = pins_q.e & ~pins_s.e;
	wire wr_rise = ~pins_q.wr_n & pins_s.wr_n;
	wire rd_rise = ~pins_q.rd_n & pins_s.rd_n;
	wire stb_fall = pins_q.strobe_n & ~pins_s.strobe_n;
	wire stb_rise = ~pins_q.strobe_n & pins_s.strobe_n;
	wire sck_rise = ~pins_q.sck & pins_s.sck;
	wire sck_fall = pins_q.sck & ~pins_s.sck;

	// ----------------------------------------------------------------
	// power-up reset and jumper capture
	// ----------------------------------------------------------------
	logic por_done; // internal reset finished
	logic ready_r;  // mode latched, accesses accepted
	vhi_mode_t mode_r;
	logic byte_wide_r;

	vhi_por #(.CYC(POR_CYC), .CW(25)) u_por (
		.pclk(pclk),
		.presetn(presetn),
		.done(por_done)
	);

	// latch jumpers
	// jumpers are static, so they are taken once when the internal reset ends
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_r <= 1'b0;
			mode_r <= MODE_NONE;
			byte_wide_r <= 1'b0;
		end else if (por_done && !ready_r) begin
			ready_r <= 1'b1;
			mode_r <= vhi_mode_t'(pins_s.jmp_mode);
			byte_wide_r <= pins_s.jmp_width;
		end
	end

	// gate early host
	// everything seen before ready_r is dropped, so an early host is ignored
	wire en_mode = ready_r && (mode_r == MODE_ENABLE);
	wire sp_mode = ready_r && (mode_r == MODE_SPLIT);
	wire se_mode = ready_r && (mode_r == MODE_SERIAL);

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	logic [7:0] tx_instr_r; // returned when reg_select is low
	logic [7:0] tx_data_r;  // returned when reg_select is high

	// ----------------------------------------------------------------
	// parallel port
	// ----------------------------------------------------------------
	logic nib_low_r;        // next nibble is the lower one
	logic [3:0] nib_hold_r; // upper nibble waiting for its partner

	wire en_wr = en_mode & e_fall & ~pins_s.rw;
	wire sp_wr = sp_mode & wr_rise;
	wire par_wr = en_wr | sp_wr;
	// a read access ends here, which advances the nibble phase
	wire par_rd_end = (en_mode & e_fall & pins_s.rw) | (sp_mode & rd_rise);
	wire en_drive = en_mode & pins_s.e & pins_s.rw;
	wire sp_drive = sp_mode & ~pins_s.rd_n;
	wire par_drive = en_drive | sp_drive;
	wire [7:0] par_rd_val = pins_s.rs ? tx_data_r : tx_instr_r;
	wire [7:0] par_out_val = byte_wide_r ? par_rd_val :
		(nib_low_r ? {par_rd_val[3:0], 4'h0} : {par_rd_val[7:4], 4'h0});
	// byte commits at once, nibbles only on the second half
	wire par_commit = par_wr & (byte_wide_r | nib_low_r);
	// byte from all lines; nibbles from the upper lines, lower lines ignored
	wire [7:0] par_word = byte_wide_r ? pins_s.db : {nib_hold_r, pins_s.db[7:4]};

	// nibble phase
	// reads and writes share one phase, as the host pairs them the same way
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nib_low_r <= 1'b0;
			nib_hold_r <= 4'h0;
		end else if ((par_wr | par_rd_end) && !byte_wide_r) begin
			nib_low_r <= ~nib_low_r;
			if (par_wr && !nib_low_r) nib_hold_r <= pins_s.db[7:4];
		end
	end

	// parallel bus drive, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_bus_out <= 8'h00;
			data_bus_oe_n <= 1'b1;
		end else begin
			data_bus_out <= par_drive ? par_out_val : 8'h00;
			data_bus_oe_n <= ~par_drive;
		end
	end

	// ----------------------------------------------------------------
	// serial port
	// ----------------------------------------------------------------
	vhi_ser_t ser_r;
	logic [3:0] bit_cnt_r;   // bits taken in the current byte
	logic [7:0] in_sh_r;     // input shifter
	logic [7:0] out_sh_r;    // read return shifter
	logic [7:0] wait_r;      // remaining read wait
	logic ser_rd_r;          // current cycle is a read
	logic ser_rs_r;          // current cycle carries display data
	logic ser_commit;
	logic ser_bad;
	logic ser_drive_r;

	wire [7:0] head = {in_sh_r[6:0], pins_s.sio};
	wire head_ok = (head[7:3] == HDR_SYNC) & ~head[0];
	wire head_last = (ser_r == SER_HEAD) & sck_rise & (bit_cnt_r == 4'd7);
	// read bit slot open only after the wait
	wire ser_out_bit = (ser_r == SER_BODY) & ser_rd_r & sck_fall & (wait_r == 8'h00) &
		(bit_cnt_r < 4'd8);
	// valid end of a write frame
	assign ser_commit = se_mode & stb_rise & (ser_r == SER_BODY) & ~ser_rd_r &
		(bit_cnt_r == 4'd8);
	assign ser_bad = se_mode & stb_rise & (ser_r != SER_IDLE) & ~ser_commit &
		~((ser_r == SER_BODY) & ser_rd_r);

	// serial frame state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_r <= SER_IDLE;
			bit_cnt_r <= 4'd0;
			in_sh_r <= 8'h00;
		end else if (!se_mode) begin
			ser_r <= SER_IDLE;
		end else if (stb_rise) begin
			ser_r <= SER_IDLE;
		end else if (stb_fall) begin
			ser_r <= SER_HEAD;
			bit_cnt_r <= 4'd0;
		end else unique case (ser_r)
			SER_IDLE, SER_SKIP: begin
			end
			SER_HEAD: if (sck_rise) begin
				in_sh_r <= head;
				bit_cnt_r <= head_last ? 4'd0 : bit_cnt_r + 4'd1;
				if (head_last) ser_r <= head_ok ? SER_BODY : SER_SKIP;
			end
			SER_BODY: begin
				if (sck_rise && !ser_rd_r) begin
					in_sh_r <= head;
					// a ninth body bit spoils the frame
					if (bit_cnt_r == 4'd8) ser_r <= SER_SKIP;
					else bit_cnt_r <= bit_cnt_r + 4'd1;
				end
				if (ser_out_bit) bit_cnt_r <= bit_cnt_r + 4'd1;
			end
		endcase
	end

	// header fields and read data load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_rd_r <= 1'b0;
			ser_rs_r <= 1'b0;
			out_sh_r <= 8'h00;
			wait_r <= 8'h00;
		end else if (head_last) begin
			ser_rd_r <= head[2];
			ser_rs_r <= head[1];
			out_sh_r <= head[1] ? tx_data_r : tx_instr_r;
			wait_r <= WAIT_LD;
		end else begin
			if (wait_r != 8'h00) wait_r <= wait_r - 8'h01;
			if (ser_out_bit) out_sh_r <= {out_sh_r[6:0], 1'b0};
		end
	end

	// drive only during read data
	// the line is released by the frame's own strobe rise, never by a clock edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ser_drive_r <= 1'b0;
			sio_out <= 1'b0;
		end else if (!se_mode || stb_rise || stb_fall) begin
			ser_drive_r <= 1'b0;
			sio_out <= 1'b0;
		end else if (ser_out_bit) begin
			ser_drive_r <= 1'b1;
			sio_out <= out_sh_r[7];
		end
	end
	assign sio_oe_n = ~ser_drive_r;

	// ----------------------------------------------------------------
	// received word and status
	// ----------------------------------------------------------------
	vhi_word_t rx_r;
	logic rx_valid_r;
	logic overrun_r;
	logic frame_err_r;
	wire rx_evt = par_commit | ser_commit;
	// the serial word is the shifter itself; head would pull in the idle line bit
	wire vhi_word_t rx_in = ser_commit ? vhi_word_t'{rs: ser_rs_r, val: in_sh_r} :
		vhi_word_t'{rs: pins_s.rs, val: par_word};

	// apb decode
	wire apb_setup = psel & ~penable;
	wire apb_done = psel & penable;
	wire hit_status = (paddr == REG_STATUS);
	wire hit_rx = (paddr == REG_RX);
	wire hit_ti = (paddr == REG_TX_INSTR);
	wire hit_td = (paddr == REG_TX_DATA);
	wire hit_any = hit_status | hit_rx | hit_ti | hit_td;
	wire wr_ok = apb_done & pwrite;
	wire rx_read = apb_done & ~pwrite & hit_rx;
	wire clr_ovr = wr_ok & hit_status & pwdata[ST_OVERRUN];
	wire clr_ferr = wr_ok & hit_status & pwdata[ST_FRAME_ERR];

	// received word; an arriving word beats the read that clears valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_r <= '0;
			rx_valid_r <= 1'b0;
			overrun_r <= 1'b0;
			frame_err_r <= 1'b0;
		end else begin
			if (rx_evt) rx_r <= rx_in;
			rx_valid_r <= rx_evt | (rx_valid_r & ~rx_read);
			overrun_r <= (rx_evt & rx_valid_r & ~rx_read) | (overrun_r & ~clr_ovr);
			frame_err_r <= ser_bad | (frame_err_r & ~clr_ferr);
		end
	end

	// writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_instr_r <= TX_RST;
			tx_data_r <= TX_RST;
		end else if (wr_ok) begin
			if (hit_ti) tx_instr_r <= pwdata[7:0];
			if (hit_td) tx_data_r <= pwdata[7:0];
		end
	end

	// read mux, sampled in the setup cycle so prdata comes from a flop
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_status) begin
			rd_mux[ST_RX_VALID] = rx_valid_r;
			rd_mux[ST_READY] = ready_r;
			rd_mux[ST_OVERRUN] = overrun_r;
			rd_mux[ST_FRAME_ERR] = frame_err_r;
			rd_mux[ST_MODE_LSB +: 2] = mode_r;
			rd_mux[ST_WIDTH] = byte_wide_r;
		end
		if (hit_rx) rd_mux[RX_RS_BIT:0] = rx_r;
		if (hit_ti) rd_mux[7:0] = tx_instr_r;
		if (hit_td) rd_mux[7:0] = tx_data_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (apb_setup) prdata <= rd_mux;
	end

	// zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = apb_done & ~hit_any;
endmodule // vhi_host_if

// ---- tb/vhi_host_if_asserts.sv ----
// vhi_host_if_asserts: port-level checks of the display host interface.
// assumes jumpers change only while presetn is low.
`timescale 1ns/1ps
module vhi_host_if_asserts
	import vhi_pkg::*;
#(
	parameter int POR_CYC = 16,
	parameter int WAIT_CYCLES = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// jumpers
	input wire logic [1:0] jmp_mode,
	input wire logic jmp_byte_wide,
	// parallel pins
	input wire logic xfer_strobe,
	input wire logic read_write,
	input wire logic reg_select,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [7:0] data_bus_in,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe_n,
	// serial pins
	input wire logic frame_strobe_n,
	input wire logic shift_clk,
	input wire logic sio_in,
	input wire logic sio_out,
	input wire logic sio_oe_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// decode helpers
	// ----
	wire logic bad_a = (paddr[1:0] != 2'h0) || (paddr > 8'h0C); // unmapped offset
	wire logic m_en = (jmp_mode == MODE_ENABLE); // enable strobe jumpers
	wire logic m_sp = (jmp_mode == MODE_SPLIT); // split strobe jumpers
	// ----
	// apb
	// ----
	AST_PREADY: assert property (pready)
		else $error("pready low");
	AST_SLVERR: assert property (pslverr == (psel && penable && bad_a))
		else $error("pslverr wrong");
	AST_BAD_RDATA: assert property (psel && penable && !pwrite && bad_a |-> prdata == 32'h0)
		else $error("unmapped read data not zero");
	// ----
	// parallel bus drive
	// ----
	AST_EN_RD_DRIVE: assert property (
		m_en && $rose(xfer_strobe) && read_write |-> ##[2:6] !data_bus_oe_n)
		else $error("enable read not driven");
	AST_EN_RD_FREE: assert property (
		m_en && $fell(xfer_strobe) |-> ##[2:6] data_bus_oe_n[*3])
		else $error("enable read not released");
	AST_WR_NO_DRIVE: assert property (
		(m_en && xfer_strobe && !read_write) || (m_sp && !write_strobe_n) |-> data_bus_oe_n)
		else $error("bus driven during write");
	AST_SP_RD_DRIVE: assert property (
		m_sp && $fell(read_strobe_n) |-> ##[2:6] !data_bus_oe_n)
		else $error("split read not driven");
	AST_NIB_LOW: assert property (
		!data_bus_oe_n && !jmp_byte_wide |-> data_bus_out[3:0] == 4'h0)
		else $error("nibble read low lines not zero");
	// ----
	// serial line
	// ----
	AST_SER_NO_DB: assert property ((jmp_mode == MODE_SERIAL) |-> data_bus_oe_n)
		else $error("data bus driven in serial mode");
	AST_SIO_FRAME: assert property (
		$fell(sio_oe_n) |-> !frame_strobe_n && (jmp_mode == MODE_SERIAL))
		else $error("serial drive outside frame");
	AST_SIO_FREE: assert property ($rose(frame_strobe_n) |-> ##[1:6] sio_oe_n)
		else $error("serial line not released");
	// main scenarios reached
	cover property (m_en && $rose(xfer_strobe) && read_write);
	cover property (m_sp && $fell(read_strobe_n));
	cover property ($fell(sio_oe_n));
	cover property (pslverr);
endmodule // vhi_host_if_asserts

bind vhi_host_if vhi_host_if_asserts #(.POR_CYC(POR_CYC), .WAIT_CYCLES(WAIT_CYCLES)) u_chk (.*);

// ---- tb/vhi_host_model.sv ----
// vhi_host_model: host processor on the display's pins.
// assumes pclk is the bench clock and tasks run one at a time.
`timescale 1ns/1ps
module vhi_host_model (
	// bench clock
	input wire logic pclk,
	// parallel control
	output logic xfer_strobe,
	output logic read_write,
	output logic reg_select,
	output logic write_strobe_n,
	output logic read_strobe_n,
	// parallel data, resolved here
	output logic [7:0] data_bus_in,
	input wire logic [7:0] data_bus_out,
	input wire logic data_bus_oe_n,
	// serial pins
	output logic frame_strobe_n,
	output logic shift_clk,
	output logic sio_in,
	input wire logic sio_out,
	input wire logic sio_oe_n
);
	logic [7:0] h_db = 8'h00; // host data lines
	logic h_oe = 1'b0; // host drives the bus
	logic h_sio = 1'b0; // host serial bit
	logic h_so = 1'b0; // host drives the serial line
	// undriven lines show the inverse, so a stale value never passes
	assign data_bus_in = !data_bus_oe_n ? data_bus_out : (h_oe ? h_db : ~h_db);
	assign sio_in = !sio_oe_n ? sio_out : (h_so ? h_sio : ~h_sio);
	// idle: strobes off, shift clock parked high
	initial begin
		xfer_strobe = 1'b0;
		read_write = 1'b0;
		reg_select = 1'b0;
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		frame_strobe_n = 1'b1;
		shift_clk = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one access, data held past the edge
	task automatic par_put(input logic split, input logic rs, input logic [7:0] v);
		read_write <= 1'b0;
		reg_select <= rs;
		h_db <= v;
		h_oe <= 1'b1;
		tick(4);
		xfer_strobe <= !split;
		write_strobe_n <= !split;
		tick(8);
		xfer_strobe <= 1'b0;
		write_strobe_n <= 1'b1;
		tick(8);
		h_oe <= 1'b0;
		// let an edge pass so a following access never re-drives in this step
		tick(1);
	endtask
	// one read access, sampled late in the strobe
	task automatic par_get(input logic split, input logic rs, output logic [7:0] v);
		read_write <= 1'b1;
		reg_select <= rs;
		tick(4);
		xfer_strobe <= !split;
		read_strobe_n <= !split;
		tick(10);
		v = data_bus_in;
		xfer_strobe <= 1'b0;
		read_strobe_n <= 1'b1;
		tick(8);
		read_write <= 1'b0;
		tick(1);
	endtask
	// framed cycle, msb first, nb bits (16 is whole)
	task automatic ser(input logic [7:0] hd, input logic [7:0] v, input int nb,
		output logic [7:0] r);
		logic [16:0] sh;
		sh = {hd, v, 1'b0};
		r = 8'h00;
		frame_strobe_n <= 1'b0;
		h_so <= 1'b1;
		tick(25);
		for (int i = 16; i > 16 - nb; i--) begin
			// read: release the line, wait past the minimum
			if (i == 8 && hd[2]) begin
				h_so <= 1'b0;
				tick(40);
			end
			shift_clk <= 1'b0;
			h_sio <= sh[i];
			tick(12);
			shift_clk <= 1'b1;
			r = {r[6:0], sio_in};
			tick(13);
		end
		frame_strobe_n <= 1'b1;
		h_so <= 1'b0;
		tick(25);
	endtask
endmodule // vhi_host_model

// ---- tb/vhi_host_interface_test.sv ----
// vhi_host_interface_test: self-checking bench of the display host interface.
// assumes the host model and the checker sit beside the design.
`timescale 1ns/1ps
module vhi_host_interface_test
	import vhi_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, jmp_byte_wide;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0] jmp_mode;
	logic xfer_strobe, read_write, reg_select, write_strobe_n, read_strobe_n;
	logic [7:0] data_bus_in, data_bus_out;
	logic data_bus_oe_n, frame_strobe_n, shift_clk, sio_in, sio_out, sio_oe_n;
	logic [31:0] exp_q[$]; // expected results, oldest first
	logic [31:0] seed = 32'h6306; // lfsr state
	logic [7:0] hv; // last host read value
	event hst_got; // host read finished
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	// short power-up timer and read wait keep the run brief
	vhi_host_if #(.POR_CYC(16), .WAIT_CYCLES(4)) i_vhi_host_if (.*);
	vhi_host_model i_host (.*);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ----
	// helpers
	// ----
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] got);
		logic [31:0] e;
		e = exp_q.pop_front();
		num_checks++;
		if (got !== e) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, e, got);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	// power cycle with jumpers set; host waits out the internal reset
	task automatic reboot(input logic [1:0] m, input logic w);
		presetn <= 1'b0;
		jmp_mode <= m;
		jmp_byte_wide <= w;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// not ready yet and the dead mode code is shown until jumpers are taken
		rd(REG_STATUS, 32'h20);
		// no pin access before the timer ends
		repeat (24) @(posedge pclk);
	endtask
	// host write or read in mode slot k (0..3 parallel, 4 serial)
	task automatic put(input int k, input logic rs, input logic [7:0] v, input int nb);
		logic [7:0] d;
		if (k == 4) i_host.ser({5'h1F, 1'b0, rs, 1'b0}, v, nb, d);
		else if (k[0]) i_host.par_put(k[1], rs, v);
		else begin
			i_host.par_put(k[1], rs, {v[7:4], seed[3:0]});
			i_host.par_put(k[1], rs, {v[3:0], seed[7:4]});
		end
	endtask
	task automatic get(input int k, input logic rs, output logic [7:0] r);
		logic [7:0] a;
		logic [7:0] b;
		if (k == 4) i_host.ser({5'h1F, 1'b1, rs, 1'b0}, 8'h00, 16, r);
		else if (k[0]) i_host.par_get(k[1], rs, r);
		else begin
			i_host.par_get(k[1], rs, a);
			i_host.par_get(k[1], rs, b);
			r = {a[7:4], b[7:4]};
		end
	endtask
	// ----
	// result watcher: apb reads and host reads
	// ----
	always @(posedge pclk) if (psel && penable && pready && !pwrite) cmp("apb_read", prdata);
	always @(hst_got) cmp("host_read", {24'h0, hv});
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			finish_test();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		vhi_mode_t m;
		logic [31:0] base, tx;
		logic [7:0] v, g;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		jmp_mode = 2'b00;
		jmp_byte_wide = 1'b0;
		for (int k = 0; k < 5; k++) begin
			m = (k < 2) ? MODE_ENABLE : (k < 4) ? MODE_SPLIT : MODE_SERIAL;
			reboot(m, k[0]);
			base = {25'h0, k[0], m, 4'h2};
			rd(REG_STATUS, base);
			rd(8'h10, 32'h0);
			seed = lfsr(seed);
			tx = seed;
			apb(1'b1, REG_TX_INSTR, {24'h0, tx[7:0]});
			apb(1'b1, REG_TX_DATA, {24'h0, tx[15:8]});
			for (int rs = 0; rs < 2; rs++) begin
				seed = lfsr(seed);
				v = seed[23:16];
				put(k, rs[0], v, 16);
				rd(REG_STATUS, base | 32'h1);
				rd(REG_RX, {23'h0, rs[0], v});
				rd(REG_STATUS, base);
				exp_q.push_back({24'h0, rs[0] ? tx[15:8] : tx[7:0]});
				get(k, rs[0], hv);
				-> hst_got;
			end
		end
		// serial faults: bad start byte, then a ninth body bit
		i_host.ser(8'hF9, 8'h5A, 16, g);
		rd(REG_STATUS, base | 32'h8);
		apb(1'b1, REG_STATUS, 32'h8);
		put(4, 1'b0, 8'h66, 17);
		rd(REG_STATUS, base | 32'h8);
		apb(1'b1, REG_STATUS, 32'h8);
		// two words without a read: second overwrites
		put(4, 1'b0, 8'hA5, 16);
		put(4, 1'b1, 8'h3C, 16);
		rd(REG_STATUS, base | 32'h5);
		rd(REG_RX, 32'h13C);
		// dead jumper code takes nothing
		reboot(MODE_NONE, 1'b0);
		i_host.par_put(1'b0, 1'b0, 8'h55);
		rd(REG_STATUS, 32'h22);
		finish_test();
	end
endmodule // vhi_host_interface_test
